/* File: rtl/status_zero_pkg.sv */
package status_zero_pkg;

  localparam logic [7:0] STATUS_ZERO_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ZERO_RESET = 8'h80;
  localparam int         PWR_UP_BIT = 7;
  localparam int         LIGHT_IRQ_BIT = 1;
  localparam int         LIGHT_NEW_BIT = 0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_HOLD
  } rd_state_type;

endpackage

/* File: rtl/pin_sync3.sv */
`timescale 1ns/1ps
module pin_sync3 (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Pin side
  input  wire logic pin_in,
  output logic      level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // Second and third stages must agree before the level changes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  assign level_out = level_r;
endmodule

/* File: rtl/sensor_status_zero_flags.sv */
// What this block does
// - Power-up event sets bit seven flag
// - Supply disturbance power-up also sets flag
// - First read after reset returns 0x80
// - Power-up restores threshold defaults; host rechecks
`timescale 1ns/1ps
module sensor_status_zero_flags
  import status_zero_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Supply monitor pin, high on a brown-out triggered internal power-up
  input  wire logic       supply_glitch,
  // Light sensor events from same-clock logic, one-cycle pulses
  input  wire logic       light_irq_event,
  input  wire logic       light_sample_event,
  // Register read port from the serial interface
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  // Threshold reload request towards the threshold register bank
  output logic            thresh_defaults
);
  import status_zero_pkg::*;

  logic       glitch_lvl;
  logic       glitch_d_r;
  logic       pwr_up_r;
  logic       light_irq_r;
  logic       light_new_r;
  logic [7:0] rd_data_r;
  logic       rd_valid_r;
  logic       thresh_r;
  rd_state_type state_r;

  // Sticky flag: a new event beats the read clear in the same cycle
  function automatic logic flag_next(input logic set_ev, input logic cur, input logic clr);
    return set_ev | (cur & ~clr);
  endfunction

  // Unused bits keep the zero pattern
  function automatic logic [7:0] pack_status(input logic pwr, input logic irq, input logic smp);
    logic [7:0] word;
    word                = READ_ZERO;
    word[PWR_UP_BIT]    = pwr;
    word[LIGHT_IRQ_BIT] = irq;
    word[LIGHT_NEW_BIT] = smp;
    return word;
  endfunction

  pin_sync3 u_glitch_sync (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .pin_in    (supply_glitch),
    .level_out (glitch_lvl)
  );

  wire       glitch_rise = glitch_lvl & ~glitch_d_r;
  wire       rd_start    = rd_en && (state_r == RD_IDLE);
  wire       hit         = rd_en && (rd_addr == STATUS_ZERO_ADDR);
  wire       take        = hit && rd_start;
  wire [7:0] status_word = pack_status(pwr_up_r, light_irq_r, light_new_r);
  wire [7:0] rd_word     = hit ? status_word : READ_ZERO;

  // Event set wins over read clear so a coincident event is not lost
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_up_r    <= STATUS_ZERO_RESET[PWR_UP_BIT];
      light_irq_r <= STATUS_ZERO_RESET[LIGHT_IRQ_BIT];
      light_new_r <= STATUS_ZERO_RESET[LIGHT_NEW_BIT];
      glitch_d_r  <= 1'b0;
    end else begin
      glitch_d_r  <= glitch_lvl;
      pwr_up_r    <= flag_next(glitch_rise, pwr_up_r, take);
      light_irq_r <= flag_next(light_irq_event, light_irq_r, take);
      light_new_r <= flag_next(light_sample_event, light_new_r, take);
    end
  end

  // Reload pulse out of reset and on every supply disturbance
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      thresh_r <= 1'b1;
    end else begin
      thresh_r <= glitch_rise;
    end
  end

  // One clear per read strobe even if rd_en is held high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= RD_IDLE;
      rd_data_r  <= READ_ZERO;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_start;
      if (rd_start) begin
        rd_data_r <= rd_word;
      end
      case (state_r)
        RD_IDLE: state_r <= rd_en ? RD_HOLD : RD_IDLE;
        RD_HOLD: state_r <= rd_en ? RD_HOLD : RD_IDLE;
        default: state_r <= RD_IDLE;
      endcase
    end
  end

  assign rd_data         = rd_data_r;
  assign rd_valid        = rd_valid_r;
  assign thresh_defaults = thresh_r;
endmodule

/* File: verif/status_zero_asserts.sv */
`timescale 1ns/1ps
module status_zero_asserts (
  input wire logic sys_clk, arst_n, supply_glitch, light_irq_event, light_sample_event,
  input wire logic rd_en, rd_valid, thresh_defaults,
  input wire logic [7:0] rd_addr, rd_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd0; $rose(rd_en) && rd_addr == 8'h00; endsequence
  property p_ans; $rose(rd_en) |=> rd_valid ##1 !rd_valid; endproperty
  a_ans: assert property (p_ans) else $error("read");
  property p_map; rd_valid && $past(rd_addr) != 8'h00 |-> rd_data == 8'h00; endproperty
  a_map: assert property (p_map) else $error("map");
  property p_pad; rd_valid |-> rd_data[6:2] == 5'h00; endproperty
  a_pad: assert property (p_pad) else $error("pad");
  property p_lgt; light_irq_event && light_sample_event ##[1:2] s_rd0 |=> rd_data[1:0] == 2'h3; endproperty
  a_lgt: assert property (p_lgt) else $error("light");
  property p_thr; $rose(supply_glitch) |-> ##[3:6] thresh_defaults; endproperty
  a_thr: assert property (p_thr) else $error("thr");
  property p_pwr; $rose(supply_glitch) ##6 s_rd0 |=> rd_data[7]; endproperty
  a_pwr: assert property (p_pwr) else $error("pwr");
endmodule
bind sensor_status_zero_flags status_zero_asserts chk (
  .sys_clk            (sys_clk),
  .arst_n             (arst_n),
  .supply_glitch      (supply_glitch),
  .light_irq_event    (light_irq_event),
  .light_sample_event (light_sample_event),
  .rd_en              (rd_en),
  .rd_valid           (rd_valid),
  .thresh_defaults    (thresh_defaults),
  .rd_addr            (rd_addr),
  .rd_data            (rd_data)
);

/* File: verif/host_reader.sv */
`timescale 1ns/1ps
module host_reader (input wire logic sys_clk, output logic rd_en = 1'b0, output logic [7:0] rd_addr = 8'h00);
  // Strobe drops a cycle between reads; stale address is inverted
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk) #1 rd_en = 1'b1;
    rd_addr = a;
    @(posedge sys_clk) #1 rd_en = 1'b0;
    rd_addr = ~a;
  endtask
endmodule

/* File: verif/tb_sensor_status_zero_flags.sv */
`timescale 1ns/1ps
module tb_sensor_status_zero_flags;
  logic       sys_clk = 1'b0, arst_n = 1'b0, supply_glitch = 1'b0;
  logic       light_irq_event = 1'b0, light_sample_event = 1'b0;
  logic       rd_en, rd_valid, thresh_defaults;
  logic [7:0] rd_addr, rd_data;
  int         mismatches = 0, n_checks = 0;
  always #25 sys_clk = ~sys_clk;
  host_reader hst (
    .sys_clk (sys_clk),
    .rd_en   (rd_en),
    .rd_addr (rd_addr)
  );
  sensor_status_zero_flags uut (
    .sys_clk            (sys_clk),
    .arst_n             (arst_n),
    .supply_glitch      (supply_glitch),
    .light_irq_event    (light_irq_event),
    .light_sample_event (light_sample_event),
    .rd_en              (rd_en),
    .rd_addr            (rd_addr),
    .rd_data            (rd_data),
    .rd_valid           (rd_valid),
    .thresh_defaults    (thresh_defaults)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Data only counts while the valid pulse stands
  function automatic logic [7:0] rdv();
    return rd_valid ? rd_data : 8'hxx;
  endfunction
  task automatic pulse(input logic irq, input logic smp);
    @(posedge sys_clk) #1 light_irq_event = irq;
    light_sample_event = smp;
    @(posedge sys_clk) #1 light_irq_event = 1'b0;
    light_sample_event = 1'b0;
  endtask
  // Reload request stands through reset and drops at the first edge
  task automatic t_reset;
    arst_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 check({7'h00, thresh_defaults}, 8'h01);
    arst_n = 1'b1;
    @(posedge sys_clk) #1 check({7'h00, thresh_defaults}, 8'h00);
    hst.rd(8'h00);
    check(rdv(), 8'h80);
    hst.rd(8'h00);
    check(rdv(), 8'h00);
  endtask
  // An unmapped read must leave pending light flags alone
  task automatic t_light;
    pulse(1'b1, 1'b1);
    hst.rd(8'h00);
    check(rdv(), 8'h03);
    pulse(1'b1, 1'b0);
    hst.rd(8'h05);
    check(rdv(), 8'h00);
    hst.rd(8'h00);
    check(rdv(), 8'h02);
    pulse(1'b0, 1'b1);
    hst.rd(8'h00);
    check(rdv(), 8'h01);
    hst.rd(8'h00);
    check(rdv(), 8'h00);
  endtask
  task automatic t_glitch;
    supply_glitch = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1 check({7'h00, thresh_defaults}, 8'h01);
    hst.rd(8'h00);
    check(rdv(), 8'h80);
    check({7'h00, thresh_defaults}, 8'h00);
    supply_glitch = 1'b0;
    hst.rd(8'h00);
    check(rdv(), 8'h00);
  endtask
  task automatic close_out;
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_reset;
    t_light;
    t_glitch;
    t_reset;
    close_out;
  end
endmodule
